// File: rtl/oni_defines.svh
// register map, field positions, reset values and fixed codes of the node identity block
`ifndef ONI_DEFINES_SVH
`define ONI_DEFINES_SVH
`define ONI_OFF_BUS_OPT   8'h20
`define ONI_OFF_ID_UPPER  8'h24
`define ONI_OFF_ID_LOWER  8'h28
`define ONI_OFF_ROM_BASE  8'h34
`define ONI_OFF_FW_LOW    8'h38
`define ONI_OFF_FW_HIGH   8'h3C
`define ONI_OFF_IRQ_STAT  8'h60
`define ONI_OFF_IRQ_MASK  8'h64
`define ONI_OFF_ID_STAT   8'h68
`define ONI_ID_RESET      32'h0000_0000
`define ONI_ROM_RESET     22'h00_0000
`define ONI_FW_RESET      32'h0000_0000
`define ONI_MAX_REC_RESET 4'hA
`define ONI_LINK_SPEED    3'h2
`define ONI_ROM_WIN_TAG   38'h3F_FFFC_0001
`define ONI_SETTLE_CYC    2'h3
`define ONI_EV_FAIL       0
`define ONI_EV_LOCK       1
`define ONI_EV_GEN        2
`define ONI_NUM_EV        3
`endif

// File: rtl/oni_pkg.sv
// types of the node identity register block
package oni_pkg;
    // identifier load states, gray coded along wait -> eeprom or firmware -> locked
    typedef enum logic [1:0] {
        ONI_ID_WAIT   = 2'h0,
        ONI_ID_EEPROM = 2'h1,
        ONI_ID_FW     = 2'h2,
        ONI_ID_LOCKED = 2'h3
    } oni_id_state_t;

    typedef struct packed {
        logic [1:0]    sync;
        logic [1:0]    settle;
        oni_id_state_t id_st;
        logic [1:0]    id_wr;
        logic [31:0]   id_upper;
        logic [31:0]   id_lower;
        logic [21:0]   rom_base;
        logic [31:0]   fw_low;
        logic [31:0]   fw_high;
        logic [1:0]    gen;
        logic [3:0]    max_rec;
        logic          rom_dirty;
        logic [2:0]    ist;
        logic [2:0]    imask;
        logic          irq;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
        logic          rd_valid;
        logic          rd_miss;
        logic [31:0]   rd_addr;
    } oni_state_t;
endpackage

// File: rtl/oni_regs.sv
// node identity, bus options, rom mapping and failed write capture registers
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "oni_defines.svh"

module oni_regs #(
    parameter int AW = 8                        // apb address width
) (
    input  wire logic          pclk,            // 50 MHz clock
    input  wire logic          presetn,         // global reset pin, async low
    input  wire logic          ce,              // clock enable, freezes state when low
    input  wire logic          psel,            // apb select
    input  wire logic          penable,         // apb enable
    input  wire logic          pwrite,          // apb direction
    input  wire logic [AW-1:0] paddr,           // apb byte address
    input  wire logic [31:0]   pwdata,          // apb write data
    output logic               pready,          // apb ready
    output logic [31:0]        prdata,          // apb read data
    output logic               pslverr,         // apb error on unmapped address
    input  wire logic          soft_reset,      // software reset pulse
    input  wire logic          bus_reset,       // 1394 bus reset pulse
    input  wire logic          rom_changed,     // host rom image changed pulse
    input  wire logic          ee_present_pin,  // eeprom detect strap, async
    input  wire logic          ee_load_valid,   // eeprom identifier word pair valid
    input  wire logic [31:0]   ee_id_upper,     // eeprom upper identifier
    input  wire logic [31:0]   ee_id_lower,     // eeprom lower identifier
    input  wire logic          rom_rd_req,      // quadlet read request pulse
    input  wire logic [47:0]   rom_rd_offset,   // 1394 offset of the read
    output logic               rom_rd_valid,    // host address result pulse
    output logic               rom_rd_miss,     // offset outside rom window
    output logic [31:0]        rom_rd_addr,     // host memory address
    input  wire logic          pw_fail,         // posted write failure pulse
    input  wire logic [47:0]   pw_offset,       // failed write destination offset
    input  wire logic [15:0]   pw_source,       // requester_node_tag
    output logic               irq              // level interrupt
);

    if (AW < 7 || AW > 32)
    begin : g_chk
        $error("oni_regs: AW must be 7..32");
    end

    oni_pkg::oni_state_t r;
    oni_pkg::oni_state_t next_r;

    // read mux, used only by the bus read path
    function automatic logic [31:0] rd_mux(input oni_pkg::oni_state_t s,
                                           input logic [AW-1:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            AW'(`ONI_OFF_BUS_OPT):  d = {16'h0000, s.max_rec, 4'h0, s.gen, 3'h0,
                                         `ONI_LINK_SPEED};
            AW'(`ONI_OFF_ID_UPPER): d = s.id_upper;
            AW'(`ONI_OFF_ID_LOWER): d = s.id_lower;
            AW'(`ONI_OFF_ROM_BASE): d = {s.rom_base, 10'h000};
            AW'(`ONI_OFF_FW_LOW):   d = s.fw_low;
            AW'(`ONI_OFF_FW_HIGH):  d = s.fw_high;
            AW'(`ONI_OFF_IRQ_STAT): d = {29'h0, s.ist};
            AW'(`ONI_OFF_IRQ_MASK): d = {29'h0, s.imask};
            AW'(`ONI_OFF_ID_STAT):  d = {28'h0, s.id_wr, s.id_st};
            default:                d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    function automatic logic mapped(input logic [AW-1:0] a);
        logic m;
        m = 1'b0;
        case (a)
            AW'(`ONI_OFF_BUS_OPT), AW'(`ONI_OFF_ID_UPPER), AW'(`ONI_OFF_ID_LOWER),
            AW'(`ONI_OFF_ROM_BASE), AW'(`ONI_OFF_FW_LOW), AW'(`ONI_OFF_FW_HIGH),
            AW'(`ONI_OFF_IRQ_STAT), AW'(`ONI_OFF_IRQ_MASK),
            AW'(`ONI_OFF_ID_STAT): m = 1'b1;
            default:               m = 1'b0;
        endcase
        return m;
    endfunction

    logic        wr_en;
    logic [2:0]  ev;
    logic [2:0]  clr;

    // next state of the whole block
    always_comb
    begin
        next_r = r;
        ev     = 3'h0;
        clr    = 3'h0;
        wr_en  = psel && penable && r.pready && pwrite;

        // eeprom strap passes two flops before use
        next_r.sync = {r.sync[0], ee_present_pin};

        // apb: no wait state, answer registered at the edge that ends the setup cycle
        next_r.pready  = psel && !penable && !r.pready;
        next_r.pslverr = psel && !penable && !r.pready && !mapped(paddr);
        if (psel && !penable && !r.pready)
        begin
            next_r.prdata = pwrite ? 32'h0000_0000 : rd_mux(r, paddr);
        end

        // software writes take effect at the completing edge
        if (wr_en)
        begin
            case (paddr)
                AW'(`ONI_OFF_BUS_OPT):
                begin
                    next_r.max_rec = pwdata[15:12];
                    next_r.gen     = pwdata[7:6];
                end
                AW'(`ONI_OFF_ROM_BASE):
                begin
                    next_r.rom_base  = pwdata[31:10];
                    next_r.rom_dirty = 1'b1;
                end
                AW'(`ONI_OFF_IRQ_STAT): clr = pwdata[2:0];
                AW'(`ONI_OFF_IRQ_MASK): next_r.imask = pwdata[2:0];
                default: ;
            endcase
        end

        // identifier load: strap sampled after settling, then one source, then frozen
        case (r.id_st)
            oni_pkg::ONI_ID_WAIT:
            begin
                next_r.settle = r.settle + 2'h1;
                if (r.settle == `ONI_SETTLE_CYC)
                begin
                    next_r.id_st = r.sync[1] ? oni_pkg::ONI_ID_EEPROM : oni_pkg::ONI_ID_FW;
                end
            end
            oni_pkg::ONI_ID_EEPROM:
            begin
                // firmware writes are ignored while the eeprom owns the identifier
                if (ee_load_valid)
                begin
                    next_r.id_upper  = ee_id_upper;
                    next_r.id_lower  = ee_id_lower;
                    next_r.id_st     = oni_pkg::ONI_ID_LOCKED;
                    next_r.rom_dirty = 1'b1;
                    ev[`ONI_EV_LOCK] = 1'b1;
                end
            end
            oni_pkg::ONI_ID_FW:
            begin
                if (wr_en && paddr == AW'(`ONI_OFF_ID_UPPER) && !r.id_wr[1])
                begin
                    next_r.id_upper = pwdata;
                    next_r.id_wr[1] = 1'b1;
                end
                if (wr_en && paddr == AW'(`ONI_OFF_ID_LOWER) && !r.id_wr[0])
                begin
                    next_r.id_lower = pwdata;
                    next_r.id_wr[0] = 1'b1;
                end
                if (&next_r.id_wr)
                begin
                    next_r.id_st     = oni_pkg::ONI_ID_LOCKED;
                    next_r.rom_dirty = 1'b1;
                    ev[`ONI_EV_LOCK] = 1'b1;
                end
            end
            oni_pkg::ONI_ID_LOCKED: ;
            default: next_r.id_st = oni_pkg::ONI_ID_WAIT;
        endcase

        if (rom_changed)
        begin
            next_r.rom_dirty = 1'b1;
        end

        // generation count steps once per bus reset after a rom change
        if (bus_reset)
        begin
            next_r.rom_dirty = 1'b0;
            if (r.rom_dirty)
            begin
                next_r.gen      = r.gen + 2'h1;
                ev[`ONI_EV_GEN] = 1'b1;
            end
        end

        // soft reset touches only the change tracker; identity and max_rec survive
        if (soft_reset)
        begin
            next_r.rom_dirty = 1'b0;
        end

        // rom window translation, base low bits are zero so a splice is an add
        next_r.rd_valid = rom_rd_req;
        next_r.rd_miss  = rom_rd_req && rom_rd_offset[47:10] != `ONI_ROM_WIN_TAG;
        if (rom_rd_req)
        begin
            next_r.rd_addr = {r.rom_base, rom_rd_offset[9:0]};
        end

        // capture only on failure, otherwise hold for a consistent read
        if (pw_fail)
        begin
            next_r.fw_low  = pw_offset[31:0];
            next_r.fw_high = {pw_source, pw_offset[47:32]};
            ev[`ONI_EV_FAIL] = 1'b1;
        end

        // sticky status, a new event wins over a same-cycle clear
        next_r.ist = (r.ist & ~clr) | ev;
        next_r.irq = |(next_r.ist & next_r.imask);
    end

    // single state register, reset only by the global reset pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r          <= '0;
            r.id_upper <= `ONI_ID_RESET;
            r.id_lower <= `ONI_ID_RESET;
            r.rom_base <= `ONI_ROM_RESET;
            r.fw_low   <= `ONI_FW_RESET;
            r.fw_high  <= `ONI_FW_RESET;
            r.max_rec  <= `ONI_MAX_REC_RESET;
            r.id_st    <= oni_pkg::ONI_ID_WAIT;
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    assign pready       = r.pready;
    assign prdata       = r.prdata;
    assign pslverr      = r.pslverr;
    assign rom_rd_valid = r.rd_valid;
    assign rom_rd_miss  = r.rd_miss;
    assign rom_rd_addr  = r.rd_addr;
    assign irq          = r.irq;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rsvd_zero;
        pready && !pwrite && paddr == AW'(`ONI_OFF_BUS_OPT)
            |-> prdata[11:8] == 4'h0 && prdata[5:3] == 3'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("option bits set");

    // a same-cycle software write of the count loses to the step
    property p_gen_step;
        ce && bus_reset && r.rom_dirty |=> r.gen == $past(r.gen) + 2'h1;
    endproperty
    a_gen_step: assert property (p_gen_step) else $error("gen not stepped");

    property p_link_speed;
        pready && !pwrite && paddr == AW'(`ONI_OFF_BUS_OPT) |-> prdata[2:0] == 3'h2;
    endproperty
    a_link_speed: assert property (p_link_speed) else $error("speed code wrong");

    property p_id_zero;
        r.id_st == oni_pkg::ONI_ID_WAIT |-> r.id_upper == 32'h0 && r.id_lower == 32'h0;
    endproperty
    a_id_zero: assert property (p_id_zero) else $error("id not zero");

    property p_ee_load;
        ce && r.id_st == oni_pkg::ONI_ID_EEPROM && ee_load_valid
            |=> r.id_upper == $past(ee_id_upper) && r.id_lower == $past(ee_id_lower)
                && r.id_st == oni_pkg::ONI_ID_LOCKED;
    endproperty
    a_ee_load: assert property (p_ee_load) else $error("eeprom load missed");

    property p_frozen;
        r.id_st == oni_pkg::ONI_ID_LOCKED |=> $stable(r.id_upper) && $stable(r.id_lower);
    endproperty
    a_frozen: assert property (p_frozen) else $error("id changed after lock");

    property p_soft_keep;
        ce && soft_reset && r.id_st == oni_pkg::ONI_ID_LOCKED
            |=> $stable(r.id_upper) && $stable(r.id_lower)
                && ($stable(r.max_rec) || $past(wr_en));
    endproperty
    a_soft_keep: assert property (p_soft_keep) else $error("soft reset hit id");

    property p_rom_map;
        ce && rom_rd_req |=> rom_rd_valid
            && rom_rd_addr == {$past(r.rom_base), $past(rom_rd_offset[9:0])}
            && rom_rd_miss == ($past(rom_rd_offset[47:10]) != `ONI_ROM_WIN_TAG);
    endproperty
    a_rom_map: assert property (p_rom_map) else $error("rom address wrong");

    property p_base_low;
        pready && !pwrite && paddr == AW'(`ONI_OFF_ROM_BASE) |-> prdata[9:0] == 10'h000;
    endproperty
    a_base_low: assert property (p_base_low) else $error("base low bits set");

    property p_fail_cap;
        ce && pw_fail |=> r.fw_low == $past(pw_offset[31:0])
            && r.fw_high == {$past(pw_source), $past(pw_offset[47:32])};
    endproperty
    a_fail_cap: assert property (p_fail_cap) else $error("capture missed");

    property p_fail_hold;
        !pw_fail |=> $stable(r.fw_low) && $stable(r.fw_high);
    endproperty
    a_fail_hold: assert property (p_fail_hold) else $error("capture moved");

    c_fw_lock: cover property (r.id_st == oni_pkg::ONI_ID_FW
                               ##[1:20] r.id_st == oni_pkg::ONI_ID_LOCKED);
    c_ee_lock: cover property (r.id_st == oni_pkg::ONI_ID_EEPROM
                               ##[1:20] r.id_st == oni_pkg::ONI_ID_LOCKED);
    c_gen:     cover property (ce && bus_reset && r.rom_dirty);
    c_irq:     cover property ($rose(irq));

endmodule

`default_nettype wire

// File: bench/oni_ee_model.sv
// serial eeprom side model that hands one identifier pair to the block
`timescale 1ns/100ps
`default_nettype none

module oni_ee_model (
    input  wire logic        pclk,  // bench clock
    input  wire logic        go,    // start one load
    input  wire logic [3:0]  lag,   // cycles of delay before the pair appears
    input  wire logic [63:0] id,    // identifier pair to hand over
    output logic             vld,   // pair valid pulse
    output logic [31:0]      up,    // upper identifier word
    output logic [31:0]      lo     // lower identifier word
);
    logic [4:0] cnt;

    initial
    begin
        vld = 1'h0;
        up = 32'h0;
        lo = 32'h0;
        cnt = 5'h0;
    end

    // words toggle outside the pulse so stale data can never pass as a good load
    always @(posedge pclk)
    begin
        if (go)
            cnt <= {1'h0, lag} + 5'h1;
        else if (cnt != 5'h0)
            cnt <= cnt - 5'h1;
        if (cnt == 5'h1)
        begin
            vld <= 1'h1;
            up <= id[63:32];
            lo <= id[31:0];
        end
        else
        begin
            vld <= 1'h0;
            up <= ~up;
            lo <= ~lo;
        end
    end
endmodule
`default_nettype wire

// File: bench/ohci_node_identity_registers_bench.sv
// self-checking bench of the node identity register block
`timescale 1ns/100ps
`default_nettype none

module ohci_node_identity_registers_bench;
    logic        pclk = 1'h0, presetn = 1'h0, ce = 1'h1, psel = 1'h0, penable = 1'h0;
    logic        pwrite = 1'h0, soft_reset = 1'h0, bus_reset = 1'h0, rom_changed = 1'h0;
    logic        ee_present_pin = 1'h0, rom_rd_req = 1'h0, pw_fail = 1'h0, go = 1'h0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rom_rd_addr, ee_up, ee_lo, u, l, b, r;
    logic [47:0] rom_rd_offset = 48'h0, pw_offset = 48'h0, o;
    logic [15:0] pw_source = 16'h0;
    logic [63:0] id = 64'h0, t;
    logic [3:0]  lag = 4'h0;
    logic        pready, pslverr, rom_rd_valid, rom_rd_miss, irq, ee_vld, e;
    int          err_count = 0, compares = 0;

    oni_regs #(.AW(8)) i_oni_regs (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .soft_reset(soft_reset), .bus_reset(bus_reset),
        .rom_changed(rom_changed), .ee_present_pin(ee_present_pin), .ee_load_valid(ee_vld),
        .ee_id_upper(ee_up), .ee_id_lower(ee_lo), .rom_rd_req(rom_rd_req),
        .rom_rd_offset(rom_rd_offset), .rom_rd_valid(rom_rd_valid), .rom_rd_miss(rom_rd_miss),
        .rom_rd_addr(rom_rd_addr), .pw_fail(pw_fail), .pw_offset(pw_offset),
        .pw_source(pw_source), .irq(irq));
    oni_ee_model i_oni_ee_model (.pclk(pclk), .go(go), .lag(lag), .id(id), .vld(ee_vld),
        .up(ee_up), .lo(ee_lo));

    always #10 pclk = ~pclk;

    // expected bus options word for a given generation count
    function automatic logic [31:0] bopt(input logic [1:0] g);
        bopt = {16'h0, 4'hA, 4'h0, g, 3'h0, 3'h2};
    endfunction

    // expected miss flag and host address of a rom window read
    function automatic logic [32:0] xl(input logic [31:0] base, input logic [47:0] off);
        xl = {!(off >= 48'hFFFF_F000_0400 && off <= 48'hFFFF_F000_07FF), base[31:10], off[9:0]};
    endfunction

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; pready is read in the edge's time step, before the design updates
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        logic ok;
        ok = 1'h0;
        rd = 32'h0;
        er = 1'h0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (int n = 0; n < 16 && !ok; n++)
        begin
            @(posedge pclk);
            ok = (pready === 1'h1);
        end
        // data and response are taken at the completing edge, only then the request drops
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (!ok)
        begin
            err_count++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0, r, e);
        chk({e, r}, {1'h0, exp});
    endtask

    // one-cycle pulse: 0 soft reset, 1 bus reset, 2 rom changed
    task automatic pulse(input int k);
        @(posedge pclk);
        soft_reset <= (k == 0);
        bus_reset <= (k == 1);
        rom_changed <= (k == 2);
        @(posedge pclk);
        {soft_reset, bus_reset, rom_changed} <= 3'h0;
    endtask

    task automatic rst(input logic strap);
        presetn <= 1'h0;
        ee_present_pin <= strap;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        repeat (6) @(posedge pclk);
    endtask

    initial
    begin
        void'($urandom(32'h06FF252F));
        rst(1'h0);
        rd(8'h24, 32'h0);
        rd(8'h28, 32'h0);
        rd(8'h34, 32'h0);
        rd(8'h20, bopt(2'h0));
        u = $urandom;
        l = $urandom;
        wr(8'h24, u);
        wr(8'h28, l);
        wr(8'h24, ~u);
        wr(8'h28, ~l);
        rd(8'h24, u);
        rd(8'h28, l);
        pulse(0);
        pulse(1);
        rd(8'h24, u);
        rd(8'h28, l);
        $display("test firmware identifier done");
        b = $urandom;
        wr(8'h34, b);
        rd(8'h34, {b[31:10], 10'h0});
        for (int i = 0; i < 12; i++)
        begin
            t = {$urandom, $urandom};
            // both window edges and the offsets just outside, then random hits and misses
            o = (i == 0) ? 48'hFFFF_F000_03FF : (i == 1) ? 48'hFFFF_F000_0400 :
                (i == 2) ? 48'hFFFF_F000_07FF : (i == 3) ? 48'hFFFF_F000_0800 :
                (i % 2) ? {38'h3F_FFFC_0001, t[9:0]} : t[47:0];
            @(posedge pclk);
            rom_rd_req <= 1'h1;
            rom_rd_offset <= o;
            @(posedge pclk);
            rom_rd_req <= 1'h0;
            @(negedge pclk);
            chk({rom_rd_valid, rom_rd_miss, rom_rd_addr}, {1'h1, xl(b, o)});
        end
        $display("test rom window done");
        t = {$urandom, $urandom};
        @(posedge pclk);
        pw_fail <= 1'h1;
        pw_offset <= t[47:0];
        pw_source <= t[63:48];
        @(posedge pclk);
        pw_fail <= 1'h0;
        pw_offset <= ~t[47:0];
        rd(8'h38, t[31:0]);
        rd(8'h3C, {t[63:48], t[47:32]});
        rd(8'h38, t[31:0]);
        rd(8'h60, 32'h3);
        chk(irq, 1'h0);
        wr(8'h64, 32'h1);
        repeat (2) @(negedge pclk);
        chk(irq, 1'h1);
        wr(8'h60, 32'h1);
        repeat (2) @(negedge pclk);
        chk(irq, 1'h0);
        rd(8'h60, 32'h2);
        wr(8'h64, 32'h0);
        apb(1'h0, 8'h44, 32'h0, r, e);
        chk({e, r}, {1'h1, 32'h0});
        $display("test capture and interrupt done");
        pulse(1);
        rd(8'h20, bopt(2'h1));
        pulse(1);
        rd(8'h20, bopt(2'h1));
        pulse(2);
        pulse(1);
        rd(8'h20, bopt(2'h2));
        $display("test generation done");
        rst(1'h1);
        rd(8'h24, 32'h0);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge pclk);
            id <= {$urandom, $urandom};
            lag <= k ? 4'h0 : 4'h3;
            go <= 1'h1;
            @(posedge pclk);
            go <= 1'h0;
            repeat (8) @(posedge pclk);
            if (k == 0)
                t = id;
        end
        wr(8'h24, ~t[63:32]);
        rd(8'h24, t[63:32]);
        rd(8'h28, t[31:0]);
        $display("test eeprom identifier done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
